// ---- hdl/rhb_filter.sv ----
// record high-pass and biquad filter block with its AHB-Lite register slave and output FIFO
// Behaviour
// - one high-pass setting serves every channel; no per-channel setting
// - high-pass stage is a first-order recursive filter removing DC
// - first-order stage: y = (N0 x + N1 x1 + D1 y1) / 2^31
// - cutoff select 01 default 0.00025fs, 10 0.002fs, 11 0.008fs, 00 programmable
// - host first-order coefficients used only while cutoff select is 00
// - first-order coefficients reset to N0 0x7FFFFFF, N1 and D1 zero
// - first-order N0, N1, D1 at page 4 registers 72-75, 76-79, 80-83
// - twelve programmable biquad sections serve the record path
// - biquad: y = (N0 x + 2N1 x1 + N2 x2 + 2D1 y1 + D2 y2) / 2^31
// - biquad sections reset to flat all-pass coefficients
// - biquad allocation 00 bypasses biquads on every channel
// - allocation 01/10/11 uses sections 1-4/1-8/1-12; section k serves channel (k-1)%4+1
// - sections take twenty registers from register 8; 1-6 page 2, 7-12 page 3
////////////////////////////////////////////////////////////////////////////////

module rhb_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count     = count_reg;

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rhb_fifo

////////////////////////////////////////////////////////////////////////////////

module rhb_filter (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire rhb_pkg::rhb_sample_s in_sample,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output rhb_pkg::rhb_sample_s     out_sample
);
  import rhb_pkg::*;

  logic               wr_q_reg;
  logic               rd_wait_reg;
  logic               in_range_reg;
  logic [9:0]         idx_reg;
  logic [31:0]        hrdata_reg;
  logic [1:0]         highpass_cutoff_select_reg;
  logic [1:0]         bq_cfg_reg;
  logic [31:0]        hpf_coef_reg [HPF_COEFS];
  logic [31:0]        bq_coef_reg [NUM_BQ][BQ_COEFS];
  rhb_state_e         state_reg;
  logic signed [31:0] cur_reg;
  logic [1:0]         chan_reg;
  logic [1:0]         nst_reg;
  logic [1:0]         stage_reg;
  logic [1:0]         bq_cycles_reg;
  logic signed [31:0] hx1_reg [NUM_CH];
  logic signed [31:0] hy1_reg [NUM_CH];
  logic signed [31:0] bx1_reg [NUM_BQ];
  logic signed [31:0] bx2_reg [NUM_BQ];
  logic signed [31:0] by1_reg [NUM_BQ];
  logic signed [31:0] by2_reg [NUM_BQ];
  logic [2:0]         pg;
  logic [6:0]         rg;
  logic [6:0]         bq_off;
  logic [6:0]         hpf_off;
  logic               bq_hit;
  logic               hpf_hit;
  logic [3:0]         dsec;
  logic [2:0]         dcf;
  logic [7:0]         rd_byte;
  logic [3:0]         sec;
  logic signed [31:0] y_next;
  logic [31:0]        hn0;
  logic [31:0]        hd1;
  logic               fifo_in_ready;
  logic [4:0]         fifo_count;

  function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] bt);
    get_byte = 8'(w >> {2'h3 - bt, 3'h0});
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] bt,
                                           input logic [7:0] b);
    logic [31:0] m;
    m = 32'(8'hFF) << {2'h3 - bt, 3'h0};
    put_byte = (w & ~m) | (32'(b) << {2'h3 - bt, 3'h0});
  endfunction

  // coefficient widened to 34 bits, optionally doubled
  function automatic logic signed [33:0] cx(input logic [31:0] c, input logic dbl);
    cx = dbl ? {c[31], c, 1'b0} : {c[31], c[31], c};
  endfunction

  function automatic logic signed [31:0] mac(
    input logic signed [33:0] c0, input logic signed [33:0] c1, input logic signed [33:0] c2,
    input logic signed [33:0] c3, input logic signed [33:0] c4,
    input logic signed [31:0] x0, input logic signed [31:0] x1, input logic signed [31:0] x2,
    input logic signed [31:0] y1, input logic signed [31:0] y2);
    logic signed [ACC_W-1:0] acc;
    acc = c0 * x0 + c1 * x1 + c2 * x2 + c3 * y1 + c4 * y2;
    acc = acc >>> COEF_SHIFT;
    // saturate when the scaled sum leaves the 32-bit sample range
    if (acc[ACC_W-1:COEF_SHIFT] != {(ACC_W-COEF_SHIFT){acc[COEF_SHIFT]}})
      mac = acc[ACC_W-1] ? {1'b1, 31'h0} : {1'b0, {31{1'b1}}};
    else
      mac = acc[31:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes complete with no wait, reads add one wait state

  assign hresp     = 1'b0;
  assign hreadyout = !rd_wait_reg;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q_reg     <= 1'b0;
      rd_wait_reg  <= 1'b0;
      in_range_reg <= 1'b0;
      idx_reg      <= '0;
    end
    else if (hready)
    begin
      wr_q_reg    <= hsel && htrans[1] && hwrite;
      rd_wait_reg <= hsel && htrans[1] && !hwrite;
      if (hsel && htrans[1])
      begin
        idx_reg      <= haddr[IDX_MSB:IDX_LSB];
        in_range_reg <= (haddr[31:IDX_MSB+1] == '0);
      end
    end
    else
    begin
      wr_q_reg    <= 1'b0;
      rd_wait_reg <= 1'b0;
    end
  end

  always_comb
  begin
    pg      = idx_reg[9:7];
    rg      = idx_reg[6:0];
    bq_off  = rg - REG_BQ_BASE;
    hpf_off = rg - REG_HPF_BASE;
    bq_hit  = in_range_reg && (pg == PG_BQ_LO || pg == PG_BQ_HI) && rg >= REG_BQ_BASE;
    hpf_hit = in_range_reg && pg == PG_HPF && rg >= REG_HPF_BASE && rg <= REG_HPF_LAST;
    dsec    = 4'(bq_off / 7'(BQ_REGS)) + ((pg == PG_BQ_HI) ? 4'(BQ_PER_PAGE) : 4'h0);
    dcf     = 3'((bq_off % 7'(BQ_REGS)) / 7'(COEF_BYTES));
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (bq_hit)
      rd_byte = get_byte(bq_coef_reg[dsec][dcf], bq_off[1:0]);
    else if (hpf_hit)
      rd_byte = get_byte(hpf_coef_reg[hpf_off[3:2]], hpf_off[1:0]);
    else if (in_range_reg && pg == PG_CTRL && rg == REG_HIGHPASS_CUTOFF_SELECT)
      rd_byte = 8'(highpass_cutoff_select_reg) << HIGHPASS_CUTOFF_SELECT_LSB;
    else if (in_range_reg && pg == PG_CTRL && rg == REG_BQ_CFG)
      rd_byte = 8'(bq_cfg_reg) << BQ_CFG_LSB;
    else if (in_range_reg && pg == PG_STAT && rg == REG_STATUS)
      rd_byte = {fifo_count, state_reg, in_ready};
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      hrdata_reg <= '0;
    else if (rd_wait_reg)
      hrdata_reg <= 32'(rd_byte);
  end

  // control fields and coefficient store, byte-wide registers in the low lane
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      highpass_cutoff_select_reg <= HIGHPASS_CUTOFF_SELECT_RST;
      bq_cfg_reg  <= BQ_CFG_RST;
      hpf_coef_reg[0] <= HPF_N0_RST;
      hpf_coef_reg[1] <= COEF_ZERO;
      hpf_coef_reg[2] <= COEF_ZERO;
      for (int s = 0; s < NUM_BQ; s++)
        for (int c = 0; c < BQ_COEFS; c++)
          bq_coef_reg[s][c] <= (c == 0) ? BQ_N0_RST : COEF_ZERO;
    end
    else if (wr_q_reg)
    begin
      if (bq_hit)
        bq_coef_reg[dsec][dcf] <= put_byte(bq_coef_reg[dsec][dcf], bq_off[1:0], hwdata[7:0]);
      else if (hpf_hit)
        hpf_coef_reg[hpf_off[3:2]] <= put_byte(hpf_coef_reg[hpf_off[3:2]], hpf_off[1:0],
                                               hwdata[7:0]);
      else if (in_range_reg && pg == PG_CTRL && rg == REG_HIGHPASS_CUTOFF_SELECT)
        highpass_cutoff_select_reg <= hwdata[HIGHPASS_CUTOFF_SELECT_LSB +: 2];
      else if (in_range_reg && pg == PG_CTRL && rg == REG_BQ_CFG)
        bq_cfg_reg <= hwdata[BQ_CFG_LSB +: 2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample datapath: one high-pass step, then the channel's biquads in turn

  assign in_ready = (state_reg == ST_IDLE);
  assign sec      = {stage_reg, chan_reg};
  // one shared cutoff setting, whatever the sample's channel
  assign hn0 = (highpass_cutoff_select_reg == HIGHPASS_CUTOFF_SELECT_PROG) ? hpf_coef_reg[0] : FIX_N0[highpass_cutoff_select_reg];
  assign hd1 = (highpass_cutoff_select_reg == HIGHPASS_CUTOFF_SELECT_PROG) ? hpf_coef_reg[2] : FIX_D1[highpass_cutoff_select_reg];

  always_comb
  begin
    if (state_reg == ST_HPF)
      y_next = mac(cx(hn0, 1'b0),
                   (highpass_cutoff_select_reg == HIGHPASS_CUTOFF_SELECT_PROG) ? cx(hpf_coef_reg[1], 1'b0) : -cx(hn0, 1'b0),
                   cx(COEF_ZERO, 1'b0), cx(hd1, 1'b0), cx(COEF_ZERO, 1'b0),
                   cur_reg, hx1_reg[chan_reg], 32'sh0, hy1_reg[chan_reg], 32'sh0);
    else
      y_next = mac(cx(bq_coef_reg[sec][0], 1'b0), cx(bq_coef_reg[sec][1], 1'b1),
                   cx(bq_coef_reg[sec][2], 1'b0), cx(bq_coef_reg[sec][3], 1'b1),
                   cx(bq_coef_reg[sec][4], 1'b0), cur_reg, bx1_reg[sec], bx2_reg[sec],
                   by1_reg[sec], by2_reg[sec]);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      cur_reg   <= '0;
      chan_reg  <= '0;
      nst_reg   <= '0;
      stage_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          if (in_valid)
          begin
            cur_reg   <= in_sample.data;
            chan_reg  <= in_sample.chan;
            nst_reg   <= bq_cfg_reg;
            state_reg <= ST_HPF;
          end
        ST_HPF:
        begin
          cur_reg   <= y_next;
          stage_reg <= '0;
          state_reg <= (nst_reg == '0) ? ST_PUSH : ST_BQ;
        end
        ST_BQ:
        begin
          cur_reg   <= y_next;
          stage_reg <= stage_reg + 1'b1;
          if (stage_reg == nst_reg - 1'b1)
            state_reg <= ST_PUSH;
        end
        ST_PUSH:
          if (fifo_in_ready)
            state_reg <= ST_IDLE;
      endcase
    end
  end

  // filter history, kept per channel for the high-pass and per section for biquads
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        hx1_reg[c] <= '0;
        hy1_reg[c] <= '0;
      end
      for (int s = 0; s < NUM_BQ; s++)
      begin
        bx1_reg[s] <= '0;
        bx2_reg[s] <= '0;
        by1_reg[s] <= '0;
        by2_reg[s] <= '0;
      end
    end
    else if (state_reg == ST_HPF)
    begin
      hx1_reg[chan_reg] <= cur_reg;
      hy1_reg[chan_reg] <= y_next;
    end
    else if (state_reg == ST_BQ)
    begin
      bx2_reg[sec] <= bx1_reg[sec];
      bx1_reg[sec] <= cur_reg;
      by2_reg[sec] <= by1_reg[sec];
      by1_reg[sec] <= y_next;
    end
  end

  rhb_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (state_reg == ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   ({chan_reg, cur_reg}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_sample),
    .count     (fifo_count)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      bq_cycles_reg <= '0;
    else if (state_reg == ST_IDLE)
      bq_cycles_reg <= '0;
    else if (state_reg == ST_BQ)
      bq_cycles_reg <= bq_cycles_reg + 1'b1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_hpf_defaults: assert property (!$past(nrst) |-> hpf_coef_reg[0] == HPF_N0_RST
    && hpf_coef_reg[1] == COEF_ZERO && hpf_coef_reg[2] == COEF_ZERO)
    else $error("first-order coefficients not at reset values");
  a_bq_defaults: assert property (!$past(nrst) |-> bq_coef_reg[11][0] == BQ_N0_RST
    && bq_coef_reg[11][3] == COEF_ZERO && bq_cfg_reg == BQ_CFG_RST)
    else $error("biquad section not flat after reset");
  a_sel_default: assert property (!$past(nrst) |-> highpass_cutoff_select_reg == HIGHPASS_CUTOFF_SELECT_RST)
    else $error("cutoff select reset value wrong");
  a_fixed_cutoff: assert property (state_reg == ST_HPF && highpass_cutoff_select_reg != HIGHPASS_CUTOFF_SELECT_PROG
    |-> hd1 == FIX_D1[highpass_cutoff_select_reg] && hn0 == FIX_N0[highpass_cutoff_select_reg])
    else $error("fixed cutoff not used");
  a_prog_cutoff: assert property (state_reg == ST_HPF && highpass_cutoff_select_reg == HIGHPASS_CUTOFF_SELECT_PROG
    |-> hn0 == hpf_coef_reg[0])
    else $error("programmed coefficient not used");
  a_bypass_path: assert property (state_reg == ST_HPF && nst_reg == 2'h0
    |=> state_reg == ST_PUSH ##0 bq_cycles_reg == 2'h0)
    else $error("biquad not bypassed");
  a_stage_count: assert property (state_reg == ST_PUSH && $past(state_reg) == ST_BQ
    |-> bq_cycles_reg == nst_reg)
    else $error("wrong number of biquad sections run");
  a_hpf_msb_write: assert property (wr_q_reg && hpf_hit && hpf_off == 7'h00
    |=> hpf_coef_reg[0][31:24] == $past(hwdata[7:0]))
    else $error("first-order N0 high byte not written");
  a_bq7_write: assert property (wr_q_reg && bq_hit && pg == PG_BQ_HI && bq_off == 7'h07
    |=> bq_coef_reg[6][1][7:0] == $past(hwdata[7:0]))
    else $error("section 7 N1 low byte not written");
  a_read_wait: assert property (rd_wait_reg |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_three_bq: cover property (state_reg == ST_BQ && stage_reg == 2'h2);
  c_prog_hpf: cover property (state_reg == ST_HPF && highpass_cutoff_select_reg == HIGHPASS_CUTOFF_SELECT_PROG);
  c_fifo_full: cover property (state_reg == ST_PUSH && !fifo_in_ready);
  c_bypass: cover property (state_reg == ST_HPF && nst_reg == 2'h0);
endmodule // rhb_filter

// ---- inc/rhb_pkg.sv ----
// package: register map, coefficient layout, reset values and types of the record filter block
package rhb_pkg;
  localparam int NUM_CH      = 4;
  localparam int NUM_BQ      = 12;
  localparam int BQ_COEFS    = 5;
  localparam int HPF_COEFS   = 3;
  localparam int COEF_BYTES  = 4;
  localparam int BQ_REGS     = 20;
  localparam int BQ_PER_PAGE = 6;
  localparam int FIFO_DEPTH  = 16;
  localparam int COEF_SHIFT  = 31;
  localparam int ACC_W       = 72;
  localparam int IDX_LSB     = 2;
  localparam int IDX_MSB     = 11;

  // register index = page * 128 + register; byte address = 4 * index
  localparam logic [2:0] PG_CTRL   = 3'h0;
  localparam logic [2:0] PG_STAT   = 3'h1;
  localparam logic [2:0] PG_BQ_LO  = 3'h2;
  localparam logic [2:0] PG_BQ_HI  = 3'h3;
  localparam logic [2:0] PG_HPF    = 3'h4;
  localparam logic [6:0] REG_HIGHPASS_CUTOFF_SELECT  = 7'h6B;
  localparam logic [6:0] REG_BQ_CFG   = 7'h6C;
  localparam logic [6:0] REG_STATUS   = 7'h00;
  localparam logic [6:0] REG_BQ_BASE  = 7'h08;
  localparam logic [6:0] REG_HPF_BASE = 7'h48;
  localparam logic [6:0] REG_HPF_LAST = 7'h53;

  // field positions and reset values
  localparam int         HIGHPASS_CUTOFF_SELECT_LSB = 0;
  localparam int         BQ_CFG_LSB  = 5;
  localparam logic [1:0] HIGHPASS_CUTOFF_SELECT_PROG = 2'h0;
  localparam logic [1:0] HIGHPASS_CUTOFF_SELECT_RST  = 2'h1;
  localparam logic [1:0] BQ_CFG_RST   = 2'h2;

  localparam logic [31:0] COEF_ZERO  = 32'h0000_0000;
  localparam logic [31:0] HPF_N0_RST = 32'h07FF_FFFF;
  localparam logic [31:0] BQ_N0_RST  = 32'h7FFF_FFFF;

  // fixed first-order cutoffs, index = cutoff select; entry 0 unused
  localparam logic [31:0] FIX_N0 [4] = '{32'h0000_0000, 32'h7FE6_429B,
                                         32'h7F32_2000, 32'h7CC8_8000};
  localparam logic [31:0] FIX_D1 [4] = '{32'h0000_0000, 32'h7FCC_8535,
                                         32'h7E64_4000, 32'h7991_0000};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HPF  = 2'b01,
    ST_BQ   = 2'b10,
    ST_PUSH = 2'b11
  } rhb_state_e;

  typedef struct packed {
    logic        [1:0]  chan;
    logic signed [31:0] data;
  } rhb_sample_s;

  localparam int SAMPLE_W = $bits(rhb_sample_s);
endpackage

// ---- bench/rhb_stream_model.sv ----
// partner model: sample source upstream and sample sink downstream of the filter block
module rhb_stream_model
  import rhb_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 stall,
  input  wire logic                 in_ready,
  output logic                      in_valid,
  output rhb_pkg::rhb_sample_s      in_sample,
  input  wire logic                 out_valid,
  output logic                      out_ready,
  input  wire rhb_pkg::rhb_sample_s out_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  rhb_sample_s got [$];
  initial in_valid = 1'b0;
  initial in_sample = '0;
  assign out_ready = !stall;
  ////////////////////////////////////////////////////////////////////////////////
  // offer one sample, hold it until taken, then scramble the idle bus
  task automatic send(input logic [1:0] ch, input logic [31:0] d);
    in_valid <= 1'b1;
    in_sample <= '{chan: ch, data: d};
    do @(posedge ref_clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_sample <= rhb_sample_s'(~in_sample);
  endtask
  always @(posedge ref_clk)
    if (out_valid === 1'b1 && out_ready)
      got.push_back(out_sample);
endmodule // rhb_stream_model

// ---- bench/tb_top.sv ----
// testbench: register access over the bus and filtered sample checks
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH t=%0t value %h expected %h", $time, a, b); end end
module tb_top
  import rhb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        in_valid;
  logic        in_ready;
  rhb_sample_s in_sample;
  logic        out_valid;
  logic        out_ready;
  rhb_sample_s out_sample;
  logic        stall   = 1'b0;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cyc = 0;
  logic [31:0] v;
  logic [31:0] ex [4] = '{32'h2000_0000, 32'h1000_0000, 32'h0FFF_FFFF, 32'h0FFF_FFFE};

  always #10 ref_clk = ~ref_clk;

  rhb_filter u_rhb_filter (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid),
    .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample)
  );
  rhb_stream_model u_rhb_stream_model (
    .ref_clk(ref_clk), .stall(stall), .in_ready(in_ready), .in_valid(in_valid),
    .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      $display("MISMATCH t=%0t run did not finish", $time);
      results();
    end
  end

  // one single AHB transfer; address phase held until hready, then data phase
  task automatic bus(input logic w, input logic [2:0] pg, input logic [6:0] r,
                     input logic [7:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, pg, r, 2'b00};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [2:0] pg, input logic [6:0] r, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, pg, r, d, q);
  endtask
  // coefficient travels most significant byte first
  task automatic wc(input logic [2:0] pg, input logic [6:0] r, input logic [31:0] c);
    for (int i = 0; i < 4; i++)
      wr(pg, r + 7'(i), c[31-8*i -: 8]);
  endtask
  task automatic rc(input logic [2:0] pg, input logic [6:0] r, output logic [31:0] c);
    logic [31:0] q;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, pg, r + 7'(i), 8'h00, q);
      c = {c[23:0], q[7:0]};
    end
  endtask
  task automatic rd(input logic [2:0] pg, input logic [6:0] r, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, pg, r, 8'h00, q);
    `CHK({hresp, q & m}, {1'b0, e})
  endtask
  // one sample through the chain; latency counted from the accepting edge
  task automatic xfer(input logic [1:0] ch, input logic [31:0] x, input logic [31:0] e,
                      input int lat);
    int n;
    rhb_sample_s s;
    u_rhb_stream_model.send(ch, x);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (out_valid !== 1'b1 && n < 50);
    @(posedge ref_clk);
    #1;
    `CHK(n, lat)
    s = u_rhb_stream_model.got.pop_back();
    `CHK(s.data, e)
    `CHK(s.chan, ch)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(PG_CTRL, REG_HIGHPASS_CUTOFF_SELECT, 32'h0000_0003, 32'h0000_0001);
    rd(PG_CTRL, REG_BQ_CFG, 32'h0000_0060, 32'h0000_0040);
    rc(PG_HPF, 7'd72, v);
    `CHK(v, 32'h07FF_FFFF)
    rc(PG_HPF, 7'd76, v);
    `CHK(v, 32'h0000_0000)
    rc(PG_HPF, 7'd80, v);
    `CHK(v, 32'h0000_0000)
    rc(PG_BQ_LO, 7'd8, v);
    `CHK(v, 32'h7FFF_FFFF)
    rc(PG_BQ_HI, 7'd108, v);
    `CHK(v, 32'h7FFF_FFFF)
    rc(PG_BQ_HI, 7'd124, v);
    `CHK(v, 32'h0000_0000)
    rd(3'h7, 7'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    wc(PG_HPF, 7'd80, 32'h8123_4567);
    rd(PG_HPF, 7'd80, 32'hFFFF_FFFF, 32'h0000_0081);
    rc(PG_HPF, 7'd80, v);
    `CHK(v, 32'h8123_4567)
    wc(PG_HPF, 7'd80, 32'h0000_0000);
    // section 7 sits at the start of the upper biquad page
    wc(PG_BQ_HI, 7'd12, 32'h0102_0304);
    rc(PG_BQ_HI, 7'd12, v);
    `CHK(v, 32'h0102_0304)
    wc(PG_BQ_HI, 7'd12, 32'h0000_0000);
    $display("test reset_and_map done");
    // programmable first-order stage, biquads bypassed
    wr(PG_CTRL, REG_HIGHPASS_CUTOFF_SELECT, 8'h00);
    wr(PG_CTRL, REG_BQ_CFG, 8'h00);
    xfer(2'd0, 32'h4000_0000, 32'h03FF_FFFF, 2);
    wc(PG_HPF, 7'd72, 32'h4000_0000);
    wc(PG_HPF, 7'd76, 32'h4000_0000);
    xfer(2'd0, 32'h2000_0000, 32'h3000_0000, 2);
    xfer(2'd0, 32'hE000_0000, 32'h0000_0000, 2);
    wc(PG_HPF, 7'd76, 32'h0000_0000);
    wc(PG_HPF, 7'd80, 32'h4000_0000);
    xfer(2'd0, 32'h4000_0000, 32'h2000_0000, 2);
    xfer(2'd0, 32'h0000_0000, 32'h1000_0000, 2);
    wc(PG_HPF, 7'd80, 32'h0000_0000);
    $display("test first_order done");
    // allocation sweep on channel 2, section 2 halves
    wc(PG_BQ_LO, 7'd28, 32'h4000_0000);
    for (int a = 0; a < 4; a++)
    begin
      wr(PG_CTRL, REG_BQ_CFG, 8'(a << 5));
      xfer(2'd1, 32'h4000_0000, ex[a], 2 + a);
    end
    wr(PG_CTRL, REG_BQ_CFG, 8'h20);
    xfer(2'd2, 32'h4000_0000, 32'h1FFF_FFFF, 3);
    wc(PG_BQ_LO, 7'd32, 32'h1000_0000);
    wc(PG_BQ_LO, 7'd36, 32'h2000_0000);
    xfer(2'd1, 32'h4000_0000, 32'h2000_0000, 3);
    $display("test biquad done");
    // fixed cutoff on an unused channel: a DC step, then its decay
    wr(PG_CTRL, REG_BQ_CFG, 8'h00);
    wr(PG_CTRL, REG_HIGHPASS_CUTOFF_SELECT, 8'h01);
    xfer(2'd3, 32'h4000_0000, FIX_N0[1] >> 1, 2);
    v = 32'((64'(FIX_D1[1]) * 64'(FIX_N0[1] >> 1)) >> 31);
    xfer(2'd3, 32'h4000_0000, v, 2);
    wr(PG_CTRL, REG_HIGHPASS_CUTOFF_SELECT, 8'h00);
    $display("test fixed_cutoff done");
    // fill the output buffer with the sink stalled, then drain it
    wr(PG_CTRL, REG_BQ_CFG, 8'h00);
    u_rhb_stream_model.got.delete();
    stall <= 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      u_rhb_stream_model.send(2'd2, 32'(2 * i));
      @(posedge ref_clk);
    end
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK(in_ready, 1'b0)
    rd(PG_STAT, REG_STATUS, 32'h0000_00FF, 32'h0000_0086);
    stall <= 1'b0;
    for (int k = 0; k < 100 && u_rhb_stream_model.got.size() < 17; k++)
      @(posedge ref_clk);
    #1;
    `CHK(u_rhb_stream_model.got.size(), 17)
    foreach (u_rhb_stream_model.got[i])
      `CHK(u_rhb_stream_model.got[i].data, 32'(i))
    $display("test buffer done");
    results();
  end
endmodule // tb_top
